// [pkg/emp_pkg.sv]
// Purpose: Shared constants of the encoder multiturn and pulse divider.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes: Encoder resolution is fixed by ENC_CPR below.
package emp_pkg;
  // Register byte offsets.
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CMD = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_LIMIT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_RATIO = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_MTURN = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_POS = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h020;
  // Field positions.
  localparam int unsigned CTRL_USAGE = 0;
  localparam int unsigned CTRL_ROTDIR = 1;
  localparam int unsigned CMD_RESTART = 0;
  localparam int unsigned CMD_ALMRST = 1;
  localparam int unsigned CMD_MTRST = 2;
  localparam int unsigned ST_ABS = 0;
  localparam int unsigned ST_ALM_MIS = 1;
  localparam int unsigned ST_ALM_BAT = 2;
  localparam int unsigned ST_FIT_INC = 3;
  localparam int unsigned ST_SINGLE = 4;
  localparam int unsigned IRQ_MIS = 0;
  localparam int unsigned IRQ_BAT = 1;
  localparam int unsigned IRQ_WRAP = 2;
  localparam int unsigned IRQ_IDX = 3;
  localparam int unsigned IRQ_W = 4;
  // Encoder usage codes.
  localparam logic USAGE_ABS = 1'b0;
  localparam logic USAGE_INC = 1'b1;
  // Multiturn limit.
  localparam int unsigned MT_W = 16;
  localparam logic [MT_W-1:0] MT_LIMIT_DEF = 16'h000a;
  // Dividing ratio, in pulses per revolution.
  localparam int unsigned RATIO_W = 16;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 16'h0010;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 16'h4000;
  localparam logic [RATIO_W-1:0] RATIO_DEF = 16'h4000;
  // Encoder counts per revolution and the divider accumulator.
  localparam int unsigned POS_W = 17;
  localparam int unsigned ACC_W = 18;
  localparam int unsigned QUAD_SHIFT = 2;
  localparam logic [ACC_W-1:0] ENC_CPR = 18'h20000;
  localparam logic [POS_W-1:0] POS_LAST = 17'h1ffff;
  localparam logic [RATIO_W-1:0] RATIO_CAP = 16'h8000;
endpackage : emp_pkg

// [logic/emp_encoder_top.sv]
// Purpose: Encoder usage, alarms, multiturn counter and pulse divider.
// Assumes: Encoder interface logic on core_clk_i delivers step pulses.
// Notes: Restart settings latch at reset release or on a restart command.
////////////////////////////////////////////////////////////////////////
// What this block does
// - Usage 0 means absolute, 1 incremental, taken only at restart.
// - Absolute use with an incremental encoder raises an alarm.
// - Encoder alarms hold until alarm reset and multiturn reset are done.
// - In absolute mode the retained position is loaded at restart.
// - The multiturn limit acts only in absolute use and latches at restart.
// - Off default, reverse from count 0 loads limit minus one.
// - Off default, forward from limit minus one wraps the count to 0.
// - Single-turn or incremental use holds the multiturn count at 0.
// - Phases A and B are a quadrature pair a quarter period apart.
// - The index output follows the encoder index without division.
// - The rotation direction setting does not change the A/B form.
// - The divider emits the latched ratio of pulses per revolution.
// - The ratio is capped by what the encoder resolution supports.
module emp_encoder_top
  import emp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic enc_step_i,
  input wire logic enc_dir_i,
  input wire logic enc_index_i,
  input wire logic enc_fitted_incr_i,
  input wire logic enc_single_turn_i,
  input wire logic enc_batt_fail_i,
  input wire logic [MT_W-1:0] enc_mturn_init_i,
  input wire logic [POS_W-1:0] enc_pos_init_i,
  output logic divided_phase_a_out_o,
  output logic divided_phase_b_out_o,
  output logic index_phase_out_o,
  output logic irq_o
);

  // Clamp a dividing ratio to its range and to the encoder resolution.
  function automatic logic [RATIO_W-1:0] clamp_ratio(
    input logic [RATIO_W-1:0] v);
    logic [RATIO_W-1:0] r;
    r = v;
    if (r < RATIO_MIN) r = RATIO_MIN;
    if (r > RATIO_MAX) r = RATIO_MAX;
    if (r > RATIO_CAP) r = RATIO_CAP;
    return r;
  endfunction : clamp_ratio

  // Quadrature phase pair {A, B} for a two-bit position count.
  function automatic logic [1:0] quad_ab(input logic [1:0] c);
    return {c[1] ^ c[0], c[1]};
  endfunction : quad_ab

  logic pready_q, pslverr_q, hit, wr_en, cap_en;
  logic [31:0] prdata_q, rdata;
  logic usage_cfg_q, rotdir_q, abs_q, boot_q, latch_now;
  logic [MT_W-1:0] limit_cfg_q, limit_q, mt_q, lim_m1;
  logic [RATIO_W-1:0] ratio_cfg_q, ratio_q;
  logic cmd_restart, cmd_almrst, cmd_mtrst;
  logic [POS_W-1:0] pos_q, acc_q, acc_d;
  logic [ACC_W-1:0] inc, sum;
  logic q_fwd, q_rev, pa_q, pb_q, pc_q;
  logic [1:0] qcnt_q, qcnt_d;
  logic mt_live, lim_on, fwd_wrap, rev_wrap, wrap_lim;
  logic alm_mis_q, alm_bat_q, ar_done_q, mr_done_q;
  logic mis_set, both_done;
  logic [IRQ_W-1:0] irq_sts_q, irq_mask_q, irq_set, irq_clr;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////
  // APB slave with one wait state; writes land on the pready edge.
  assign wr_en = psel_i & penable_i & pready_q & pwrite_i;
  assign cap_en = psel_i & penable_i & ~pready_q;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= cap_en;
      pslverr_q <= cap_en & ~hit;
      if (cap_en && !pwrite_i) prdata_q <= rdata;
    end
  end

  // Read decode; an unmapped address answers with pslverr.
  always_comb begin
    rdata = '0;
    hit = 1'b1;
    case (paddr_i)
      OFS_CTRL: begin
        rdata[CTRL_USAGE] = usage_cfg_q;
        rdata[CTRL_ROTDIR] = rotdir_q;
      end
      OFS_CMD: rdata = '0;
      OFS_LIMIT: rdata[MT_W-1:0] = limit_cfg_q;
      OFS_RATIO: rdata[RATIO_W-1:0] = ratio_cfg_q;
      OFS_STATUS: begin
        rdata[ST_ABS] = abs_q;
        rdata[ST_ALM_MIS] = alm_mis_q;
        rdata[ST_ALM_BAT] = alm_bat_q;
        rdata[ST_FIT_INC] = enc_fitted_incr_i;
        rdata[ST_SINGLE] = enc_single_turn_i;
      end
      OFS_MTURN: rdata[MT_W-1:0] = mt_q;
      OFS_POS: rdata[POS_W-1:0] = pos_q;
      OFS_IRQ_STS: rdata[IRQ_W-1:0] = irq_sts_q;
      OFS_IRQ_MASK: rdata[IRQ_W-1:0] = irq_mask_q;
      default: hit = 1'b0;
    endcase
  end

  // Command pulses exist only for the write's completing cycle.
  assign cmd_restart = wr_en & (paddr_i == OFS_CMD) & pwdata_i[CMD_RESTART];
  assign cmd_almrst = wr_en & (paddr_i == OFS_CMD) & pwdata_i[CMD_ALMRST];
  assign cmd_mtrst = wr_en & (paddr_i == OFS_CMD) & pwdata_i[CMD_MTRST];

  // Writable settings; the rotation setting is kept but never reaches A/B.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      usage_cfg_q <= USAGE_ABS;
      rotdir_q <= 1'b0;
      limit_cfg_q <= MT_LIMIT_DEF;
      ratio_cfg_q <= RATIO_DEF;
    end else if (wr_en) begin
      if (paddr_i == OFS_CTRL) begin
        usage_cfg_q <= pwdata_i[CTRL_USAGE];
        rotdir_q <= pwdata_i[CTRL_ROTDIR];
      end
      if (paddr_i == OFS_LIMIT) limit_cfg_q <= pwdata_i[MT_W-1:0];
      if (paddr_i == OFS_RATIO) ratio_cfg_q <= pwdata_i[RATIO_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Restart latch: once after reset release, and on each restart command.
  assign latch_now = boot_q | cmd_restart;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      boot_q <= 1'b1;
      abs_q <= 1'b1;
      limit_q <= MT_LIMIT_DEF;
      ratio_q <= RATIO_DEF;
    end else begin
      boot_q <= 1'b0;
      if (latch_now) begin
        abs_q <= (usage_cfg_q == USAGE_ABS);
        limit_q <= limit_cfg_q;
        ratio_q <= clamp_ratio(ratio_cfg_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Single-turn position; wraps mark whole revolutions.
  assign fwd_wrap = enc_step_i & enc_dir_i & (pos_q == POS_LAST);
  assign rev_wrap = enc_step_i & ~enc_dir_i & (pos_q == '0);

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pos_q <= '0;
    end else if (latch_now) begin
      pos_q <= (usage_cfg_q == USAGE_ABS) ? enc_pos_init_i : '0;
    end else if (enc_step_i) begin
      if (enc_dir_i) pos_q <= fwd_wrap ? '0 : pos_q + 1'b1;
      else pos_q <= rev_wrap ? POS_LAST : pos_q - 1'b1;
    end
  end

  // Multiturn count; the limit acts only when set off its default.
  assign mt_live = abs_q & ~enc_single_turn_i;
  assign lim_on = (limit_q != MT_LIMIT_DEF);
  assign lim_m1 = limit_q - 1'b1;
  assign wrap_lim = mt_live & lim_on & ~latch_now & ~cmd_mtrst &
    ((fwd_wrap & (mt_q == lim_m1)) | (rev_wrap & (mt_q == '0)));

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mt_q <= '0;
    end else if (latch_now) begin
      mt_q <= ((usage_cfg_q == USAGE_ABS) && !enc_single_turn_i) ?
        enc_mturn_init_i : '0;
    end else if (!mt_live || cmd_mtrst) begin
      mt_q <= '0;
    end else if (fwd_wrap) begin
      mt_q <= (lim_on && mt_q == lim_m1) ? '0 : mt_q + 1'b1;
    end else if (rev_wrap) begin
      mt_q <= (lim_on && mt_q == '0) ? lim_m1 : mt_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate divider: each count adds four times the ratio, so one revolution
  // yields four quadrature edges per output pulse; at most one per count.
  always_comb begin
    inc = ACC_W'(ratio_q) << QUAD_SHIFT;
    sum = ACC_W'(acc_q) + inc;
    acc_d = acc_q;
    q_fwd = 1'b0;
    q_rev = 1'b0;
    if (enc_step_i && enc_dir_i) begin
      if (sum >= ENC_CPR) begin
        acc_d = POS_W'(sum - ENC_CPR);
        q_fwd = 1'b1;
      end else begin
        acc_d = POS_W'(sum);
      end
    end else if (enc_step_i) begin
      if (ACC_W'(acc_q) < inc) begin
        acc_d = POS_W'(ACC_W'(acc_q) + ENC_CPR - inc);
        q_rev = 1'b1;
      end else begin
        acc_d = POS_W'(ACC_W'(acc_q) - inc);
      end
    end
    qcnt_d = qcnt_q;
    if (q_fwd) qcnt_d = qcnt_q + 1'b1;
    if (q_rev) qcnt_d = qcnt_q - 1'b1;
  end

  // Output phases follow motion only, so reverse mode keeps the same form.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      acc_q <= '0;
      qcnt_q <= '0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      pc_q <= 1'b0;
    end else begin
      acc_q <= latch_now ? '0 : acc_d;
      qcnt_q <= qcnt_d;
      {pa_q, pb_q} <= quad_ab(qcnt_d);
      pc_q <= enc_index_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Encoder alarms; a new raise restarts the two clearing operations.
  assign mis_set = latch_now & (usage_cfg_q == USAGE_ABS) & enc_fitted_incr_i;
  assign both_done = ar_done_q & mr_done_q;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      alm_mis_q <= 1'b0;
      alm_bat_q <= 1'b0;
      ar_done_q <= 1'b0;
      mr_done_q <= 1'b0;
    end else begin
      if (mis_set) alm_mis_q <= 1'b1;
      else if (both_done) alm_mis_q <= 1'b0;
      if (enc_batt_fail_i) alm_bat_q <= 1'b1;
      else if (both_done) alm_bat_q <= 1'b0;
      if (mis_set || enc_batt_fail_i || both_done) begin
        ar_done_q <= 1'b0;
        mr_done_q <= 1'b0;
      end else begin
        if (cmd_almrst) ar_done_q <= 1'b1;
        if (cmd_mtrst) mr_done_q <= 1'b1;
      end
    end
  end

  // Sticky interrupt flags, write one to clear; a new event beats a clear.
  assign irq_set = {enc_index_i, wrap_lim, enc_batt_fail_i, mis_set};
  assign irq_clr = (wr_en && paddr_i == OFS_IRQ_STS) ?
    pwdata_i[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      irq_sts_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
      if (wr_en && paddr_i == OFS_IRQ_MASK)
        irq_mask_q <= pwdata_i[IRQ_W-1:0];
      irq_q <= |(irq_sts_q & irq_mask_q);
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign divided_phase_a_out_o = pa_q;
  assign divided_phase_b_out_o = pb_q;
  assign index_phase_out_o = pc_q;
  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the block's own outputs and state.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_usage_latch: assert property (
    !latch_now |=> $stable(abs_q))
    else $error("usage changed without restart");
  chk_mismatch_raise: assert property (
    mis_set |=> alm_mis_q ##1 alm_mis_q)
    else $error("mismatch alarm not raised");
  chk_alarm_hold: assert property (
    $fell(alm_mis_q) || $fell(alm_bat_q) |-> $past(both_done))
    else $error("alarm cleared early");
  chk_pos_reload: assert property (
    boot_q |=> pos_q == $past(enc_pos_init_i))
    else $error("position not reloaded at boot");
  chk_limit_latch: assert property (
    !latch_now |=> $stable(limit_q))
    else $error("limit changed without restart");
  chk_rev_wrap: assert property (
    wrap_lim && rev_wrap |=> mt_q == $past(lim_m1))
    else $error("reverse wrap value wrong");
  chk_fwd_wrap: assert property (
    wrap_lim && fwd_wrap |=> mt_q == '0)
    else $error("forward wrap value wrong");
  chk_mturn_zero: assert property (
    !mt_live && !latch_now |=> mt_q == '0)
    else $error("multiturn not held at zero");
  chk_quad_single: assert property (
    !($changed(pa_q) && $changed(pb_q)))
    else $error("both phases moved at once");
  chk_index_pass: assert property (
    ##1 pc_q == $past(enc_index_i))
    else $error("index output not passed through");
  chk_fwd_lead: assert property (
    q_fwd && !pa_q && !pb_q |=> pa_q && !pb_q)
    else $error("phase A does not lead forward");
  chk_ratio_cap: assert property (
    ratio_q <= RATIO_CAP && ratio_q >= RATIO_MIN)
    else $error("ratio out of range");

  cov_mt_wrap: cover property (wrap_lim ##1 irq_sts_q[IRQ_WRAP]);
  cov_alarm_clear: cover property (alm_mis_q ##1 !alm_mis_q);
  cov_rev_edge: cover property (q_rev ##[1:64] q_rev);
  cov_restart: cover property (cmd_restart ##1 !abs_q);

endmodule : emp_encoder_top

// [testbench/emp_host_model.sv]
// Purpose: Host controller that decodes the divided quadrature feedback.
// Assumes: Phases are sampled on the core clock, no glitches between edges.
// Notes: A jump of both phases at once is counted as a bad transition.
////////////////////////////////////////////////////////////////////////
module emp_host_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic index_i,
  output int count_o,
  output int bad_o,
  output int index_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prev_q;
  logic idx_q;

  // Next state of a forward step, A leading B.
  function automatic logic [1:0] fwd_next(input logic [1:0] s);
    case (s)
      2'b00: return 2'b10;
      2'b10: return 2'b11;
      2'b11: return 2'b01;
      default: return 2'b00;
    endcase
  endfunction : fwd_next

  // Count each phase edge with direction, and index rising edges.
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      count_o <= 0;
      bad_o <= 0;
      index_o <= 0;
    end else if ({phase_a_i, phase_b_i} == fwd_next(prev_q)) begin
      count_o <= count_o + 1;
    end else if (prev_q == fwd_next({phase_a_i, phase_b_i})) begin
      count_o <= count_o - 1;
    end else if ({phase_a_i, phase_b_i} != prev_q) begin
      bad_o <= bad_o + 1;
    end
    if (nrst_i && index_i && !idx_q) begin
      index_o <= index_o + 1;
    end
    prev_q <= {phase_a_i, phase_b_i};
    idx_q <= index_i;
  end
endmodule : emp_host_model

// [testbench/emp_encoder_top_test.sv]
// Purpose: Self-checking bench of the encoder multiturn and divider block.
// Assumes: One wait state on the register bus, as the designer states.
// Notes: Apart from two clamp corners, ratios and step counts are random from a fixed seed.
////////////////////////////////////////////////////////////////////////
module emp_encoder_top_test
  import emp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, pa, pb, pc, irq, e;
  logic step = 1'b0;
  logic dir = 1'b0;
  logic idx = 1'b0;
  logic fit_inc = 1'b0;
  logic single = 1'b0;
  logic batt = 1'b0;
  logic [MT_W-1:0] mt_init = 16'h0003;
  logic [POS_W-1:0] pos_init = 17'h00100;
  logic [31:0] q;
  logic [31:0] seed = 32'h000100f8;
  int host_cnt, host_bad, host_idx, num_errors, tests_run, c0, n, r;

  emp_encoder_top dut (.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .enc_step_i(step), .enc_dir_i(dir),
    .enc_index_i(idx), .enc_fitted_incr_i(fit_inc),
    .enc_single_turn_i(single), .enc_batt_fail_i(batt),
    .enc_mturn_init_i(mt_init), .enc_pos_init_i(pos_init),
    .divided_phase_a_out_o(pa), .divided_phase_b_out_o(pb),
    .index_phase_out_o(pc), .irq_o(irq));
  emp_host_model host (.clk_i(clk), .nrst_i(nrst), .phase_a_i(pa),
    .phase_b_i(pb), .index_i(pc), .count_o(host_cnt), .bad_o(host_bad),
    .index_o(host_idx));

  // Free running core clock.
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Forward phase edges expected from n steps after a fresh restart.
  function automatic int exp_edges(input int n, input int r);
    longint t;
    if (r < 16) r = 16;
    if (r > 16384) r = 16384;
    t = longint'(n) * 4 * r;
    return int'(t / 131072);
  endfunction : exp_edges

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One bus transfer; the wait for ready is bounded so a hang shows.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    if (k >= 20) chk(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd

  task automatic restart();
    apb(1'b1, OFS_CMD, 32'h00000001);
    repeat (3) @(posedge clk);
  endtask : restart

  task automatic steps(input int k, input logic fwd);
    repeat (k) begin
      @(posedge clk);
      step <= 1'b1;
      dir <= fwd;
    end
    @(posedge clk);
    step <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : steps

  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset defaults, wraps, alarms, divider, index.
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_LIMIT, 32'h0000000a);
    rd(OFS_RATIO, 32'h00004000);
    rd(OFS_POS, 32'h00000100);
    rd(OFS_MTURN, 32'h00000003);
    rd(OFS_STATUS, 32'h00000001);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Limit 5 puts the wrap points at 0 and 4.
    apb(1'b1, OFS_LIMIT, 32'h00000005);
    mt_init <= 16'h0004;
    pos_init <= 17'h1ffff;
    restart();
    steps(1, 1'b1);
    rd(OFS_MTURN, 32'h0);
    rd(OFS_IRQ_STS, 32'h00000004);
    steps(1, 1'b0);
    rd(OFS_MTURN, 32'h00000004);
    // Mismatch and battery alarms need both clearing operations.
    fit_inc <= 1'b1;
    apb(1'b1, OFS_IRQ_STS, 32'h0000000f);
    restart();
    rd(OFS_STATUS, 32'h0000000b);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    batt <= 1'b1;
    @(posedge clk);
    batt <= 1'b0;
    apb(1'b1, OFS_CMD, 32'h00000002);
    rd(OFS_STATUS, 32'h0000000f);
    apb(1'b1, OFS_CMD, 32'h00000004);
    rd(OFS_STATUS, 32'h00000009);
    apb(1'b1, OFS_IRQ_STS, 32'h0000000f);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Incremental use and a single-turn encoder both pin the count.
    apb(1'b1, OFS_CTRL, 32'h00000001);
    restart();
    steps(1, 1'b0);
    rd(OFS_MTURN, 32'h0);
    rd(OFS_STATUS, 32'h00000008);
    fit_inc <= 1'b0;
    single <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0);
    restart();
    steps(1, 1'b1);
    rd(OFS_MTURN, 32'h0);
    single <= 1'b0;
    // Divider: two clamp corners, then random ratios and directions.
    for (int i = 0; i < 5; i++) begin
      r = (i == 0) ? 65535 : (i == 1) ? 8 : 16 + int'(rnd() % 16369);
      n = (i < 2) ? 4096 : 1 + int'(rnd() % 2500);
      apb(1'b1, OFS_RATIO, 32'(r));
      apb(1'b1, OFS_CTRL, {30'h0, rnd() % 2 == 1, 1'b0});
      restart();
      c0 = host_cnt;
      steps(n, 1'b1);
      chk(32'(host_cnt - c0), 32'(exp_edges(n, r)));
      steps(n, 1'b0);
      chk(32'(host_cnt), 32'(c0));
    end
    chk(32'(host_bad), 32'h0);
    // Index passes through one cycle late.
    @(posedge clk);
    idx <= 1'b1;
    @(posedge clk);
    idx <= 1'b0;
    #1;
    chk({31'h0, pc}, 32'h1);
    @(posedge clk);
    #1;
    chk({31'h0, pc}, 32'h0);
    chk(32'(host_idx), 32'h1);
    // Index and the limit wraps of the divider runs are both left flagged.
    rd(OFS_IRQ_STS, 32'h0000000c);
    // A second reset in mid-run restores the defaults and reloads.
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_LIMIT, 32'h0000000a);
    rd(OFS_MTURN, 32'h00000004);
    wrap_up();
  end

  // Watchdog well beyond the longest expected run.
  initial begin
    #800000;
    num_errors++;
    wrap_up();
  end
endmodule : emp_encoder_top_test
